/* File: rtl/ext_data_or_stack_ops.v */
// Overview of operation
// RULE1 - load_external moves a byte between external memory at a pair and a register
// RULE2 - load_external_autoinc copies a byte, then bumps register and pair; 18 cycles
// RULE3 - external data forms exist only when the external data space option is set
// RULE4 - load_program_autoinc stores register byte to program memory, then bumps both
// RULE5 - no-operation changes nothing, flags kept, and takes six cycles
// RULE6 - OR stores dst OR src into dst, source left alone
// RULE7 - OR sets Z on zero, S from bit 7, clears V, keeps C, D, H
// RULE8 - operand high nibble 1110B selects a working register by its low nibble
// RULE9 - opcode 42 then one byte: high nibble dst, low nibble src
// RULE10 - pop reads stack location first, then increments stack pointer
// RULE11 - stack pointer lives in control registers FEH and FFH
// RULE12 - pop uses opcode 50 direct and 51 indirect, one operand byte
// RULE13 - external stack reads use the full 16-bit stack pointer
// RULE14 - push 70 takes 10 internal or 12 external; 71 takes 10 always
// RULE15 - push decrements stack pointer first, then writes source there
// RULE16 - pointer pair: even register is high byte, next odd is low byte
`timescale 1ns/10ps
`include "ext_ops_defs.vh"
module ext_data_or_stack_ops #(
  parameter HAS_EXT_DATA = 1
) (
  input  wire        mclk,
  input  wire        srst,
  input  wire        start,
  input  wire [7:0]  opcode,
  input  wire [7:0]  operand,
  input  wire [3:0]  rp,
  input  wire        ext_stack,
  input  wire [7:0]  flags_in,
  input  wire [7:0]  rf_rdata,
  input  wire [7:0]  mem_rdata,
  output wire        busy,
  output reg         done,
  output reg         illegal,
  output reg  [7:0]  rf_addr,
  output reg         rf_we,
  output reg  [7:0]  rf_wdata,
  output reg  [7:0]  flags_out,
  output reg         flags_we,
  output reg  [15:0] mem_addr,
  output reg         mem_rd,
  output reg         mem_we,
  output reg  [7:0]  mem_wdata,
  output reg         mem_is_prog,
  output reg  [15:0] stack_pointer_pair
);
  // ==========================================
  // states
  localparam S_IDLE  = 4'd0;
  localparam S_RDA   = 4'd1;
  localparam S_RDB   = 4'd2;
  localparam S_RDC   = 4'd3;
  localparam S_RDD   = 4'd4;
  localparam S_XFER  = 4'd5;
  localparam S_WB    = 4'd6;
  localparam S_INCA  = 4'd7;
  localparam S_INCB  = 4'd8;
  localparam S_INCC  = 4'd9;
  localparam S_WAIT  = 4'd10;

  reg [3:0]  state;
  reg [7:0]  op;
  reg [7:0]  opnd;
  reg [7:0]  ptr_hi;
  reg [7:0]  ptr_lo;
  reg [7:0]  reg_ptr;
  reg [7:0]  data;
  reg [7:0]  dst_addr;
  reg [4:0]  cycles;
  wire       last;
  wire [7:0] opnd_addr;
  wire [7:0] ind_addr;
  wire [15:0] pair_next;

  operand_resolve u_opnd (
    .operand (opnd),
    .rp      (rp),
    .address (opnd_addr)
  );
  operand_resolve u_ind (
    .operand (data),
    .rp      (rp),
    .address (ind_addr)
  );
  cycle_timer #(.W(5)) u_timer (
    .mclk  (mclk),
    .srst  (srst),
    .load  (start && state == S_IDLE),
    .count (cycles),
    .last  (last)
  );

  wire is_ext = (opcode == `OP_LDX_LOAD) || (opcode == `OP_LDX_STORE) ||
                (opcode == `OP_LDX_AI_LOAD) || (opcode == `OP_LDX_AI_STORE);
  wire known  = is_ext || opcode == `OP_LDC_AUTOINC_ST || opcode == `OP_NOP ||
                opcode == `OP_OR_RR || opcode == `OP_POP_R || opcode == `OP_POP_IR ||
                opcode == `OP_PUSH_R || opcode == `OP_PUSH_IR;
  wire refuse = !known || (is_ext && HAS_EXT_DATA == 0); // RULE3

  always @* begin
    if (refuse)
      cycles = `CYC_ILLEGAL;
    else if (opcode == `OP_NOP)
      cycles = `CYC_NOP; // RULE5
    else if (opcode == `OP_LDX_AI_LOAD || opcode == `OP_LDX_AI_STORE)
      cycles = `CYC_LDX_AI; // RULE2
    else if (opcode == `OP_LDX_LOAD || opcode == `OP_LDX_STORE || opcode == `OP_LDC_AUTOINC_ST)
      cycles = `CYC_LDX;
    else if (opcode == `OP_OR_RR)
      cycles = `CYC_OR;
    else if (opcode == `OP_PUSH_R)
      cycles = ext_stack ? `CYC_PUSH_EXT : `CYC_PUSH_INT; // RULE14
    else if (opcode == `OP_PUSH_IR)
      cycles = `CYC_PUSH_INT; // RULE14
    else
      cycles = `CYC_POP;
  end

  assign busy = (state != S_IDLE);
  // even register high, odd register low
  assign pair_next = {ptr_hi, ptr_lo} + 16'h0001; // RULE16

  wire pop_op   = (op == `OP_POP_R) || (op == `OP_POP_IR);
  wire push_op  = (op == `OP_PUSH_R) || (op == `OP_PUSH_IR);
  wire auto_op  = (op == `OP_LDX_AI_LOAD) || (op == `OP_LDX_AI_STORE) ||
                  (op == `OP_LDC_AUTOINC_ST);
  wire load_dir = (op == `OP_LDX_LOAD) || (op == `OP_LDX_AI_LOAD);
  wire [7:0] or_result = data | rf_rdata; // RULE6

  // ==========================================
  // sequencer
  always @(posedge mclk) begin
    if (srst) begin
      state <= S_IDLE;
      op <= 8'h00;
      opnd <= 8'h00;
      ptr_hi <= 8'h00;
      ptr_lo <= 8'h00;
      reg_ptr <= 8'h00;
      data <= 8'h00;
      dst_addr <= 8'h00;
      done <= 1'b0;
      illegal <= 1'b0;
      rf_addr <= 8'h00;
      rf_we <= 1'b0;
      rf_wdata <= 8'h00;
      flags_out <= 8'h00;
      flags_we <= 1'b0;
      mem_addr <= 16'h0000;
      mem_rd <= 1'b0;
      mem_we <= 1'b0;
      mem_wdata <= 8'h00;
      mem_is_prog <= 1'b0;
      stack_pointer_pair <= `SP_RESET;
    end else begin
      done <= 1'b0;
      rf_we <= 1'b0;
      flags_we <= 1'b0;
      mem_rd <= 1'b0;
      mem_we <= 1'b0;
      // software writes to FEH/FFH reach the stack pointer
      if (rf_we && rf_addr == `SP_HIGH_ADDR)
        stack_pointer_pair[15:8] <= rf_wdata; // RULE11
      if (rf_we && rf_addr == `SP_LOW_ADDR)
        stack_pointer_pair[7:0] <= rf_wdata; // RULE11
      case (state)
        S_IDLE: begin
          if (start) begin
            op <= opcode;
            opnd <= operand;
            illegal <= refuse;
            if (refuse || opcode == `OP_NOP)
              state <= S_WAIT; // RULE5
            else if (opcode == `OP_OR_RR) begin
              rf_addr <= {rp, operand[7:4]}; // RULE9
              state <= S_RDA;
            end else if (opcode == `OP_POP_R || opcode == `OP_POP_IR) begin
              mem_addr <= stack_pointer_pair; // RULE13
              mem_is_prog <= 1'b0;
              mem_rd <= ext_stack;
              rf_addr <= stack_pointer_pair[7:0];
              state <= S_RDA;
            end else begin
              rf_addr <= {rp, operand[3:1], 1'b0}; // RULE16
              state <= S_RDA;
            end
          end
        end
        S_RDA: begin
          if (op == `OP_OR_RR) begin
            data <= rf_rdata;
            rf_addr <= {rp, opnd[3:0]}; // RULE9
            state <= S_RDB;
          end else if (pop_op) begin
            data <= ext_stack ? mem_rdata : rf_rdata; // RULE10
            rf_addr <= opnd_addr;
            state <= (op == `OP_POP_IR) ? S_RDB : S_WB; // RULE12
          end else if (push_op) begin
            ptr_hi <= rf_rdata;
            rf_addr <= opnd_addr;
            state <= (op == `OP_PUSH_IR) ? S_RDB : S_XFER;
          end else begin
            ptr_hi <= rf_rdata;
            rf_addr <= {rp, opnd[3:1], 1'b1};
            state <= S_RDB;
          end
        end
        S_RDB: begin
          if (op == `OP_OR_RR) begin
            rf_addr <= {rp, opnd[7:4]};
            rf_wdata <= or_result;
            rf_we <= 1'b1;
            flags_out <= flags_in;
            flags_out[`FLAG_Z] <= (or_result == 8'h00); // RULE7
            flags_out[`FLAG_S] <= or_result[7]; // RULE7
            flags_out[`FLAG_V] <= 1'b0; // RULE7
            flags_we <= 1'b1;
            state <= S_WAIT;
          end else if (op == `OP_POP_IR) begin
            dst_addr <= (rf_rdata[7:4] == `WREG_NIBBLE) ? {rp, rf_rdata[3:0]} : rf_rdata;
            state <= S_WB;
          end else if (op == `OP_PUSH_IR) begin
            rf_addr <= (rf_rdata[7:4] == `WREG_NIBBLE) ? {rp, rf_rdata[3:0]} : rf_rdata;
            state <= S_XFER;
          end else begin
            ptr_lo <= rf_rdata;
            rf_addr <= {rp, opnd[7:4]};
            state <= S_RDC;
          end
        end
        S_RDC: begin
          reg_ptr <= rf_rdata;
          if (auto_op)
            rf_addr <= (rf_rdata[7:4] == `WREG_NIBBLE) ? {rp, rf_rdata[3:0]} : rf_rdata;
          state <= S_RDD;
        end
        S_RDD: begin
          mem_addr <= {ptr_hi, ptr_lo}; // RULE1
          mem_is_prog <= (op == `OP_LDC_AUTOINC_ST); // RULE4
          if (load_dir)
            mem_rd <= 1'b1;
          else begin
            mem_wdata <= rf_rdata;
            mem_we <= 1'b1; // RULE1
          end
          state <= S_XFER;
        end
        S_XFER: begin
          if (push_op) begin
            // decrement before write
            stack_pointer_pair <= stack_pointer_pair - 16'h0001; // RULE15
            mem_addr <= stack_pointer_pair - 16'h0001; // RULE15
            mem_wdata <= rf_rdata;
            mem_is_prog <= 1'b0;
            mem_we <= ext_stack;
            rf_addr <= stack_pointer_pair[7:0] - 8'h01;
            rf_wdata <= rf_rdata;
            rf_we <= !ext_stack;
            state <= S_WAIT;
          end else if (load_dir) begin
            rf_addr <= (op == `OP_LDX_LOAD) ? {rp, opnd[7:4]} : rf_addr;
            rf_wdata <= mem_rdata; // RULE1
            rf_we <= 1'b1;
            state <= auto_op ? S_INCA : S_WAIT;
          end else
            state <= auto_op ? S_INCA : S_WAIT;
        end
        S_WB: begin
          rf_addr <= (op == `OP_POP_IR) ? dst_addr : rf_addr;
          rf_wdata <= data;
          rf_we <= 1'b1;
          stack_pointer_pair <= stack_pointer_pair + 16'h0001; // RULE10
          state <= S_WAIT;
        end
        S_INCA: begin
          rf_addr <= {rp, opnd[7:4]};
          rf_wdata <= reg_ptr + 8'h01; // RULE2 RULE4
          rf_we <= 1'b1;
          state <= S_INCB;
        end
        S_INCB: begin
          rf_addr <= {rp, opnd[3:1], 1'b0};
          rf_wdata <= pair_next[15:8]; // RULE2 RULE4
          rf_we <= 1'b1;
          state <= S_INCC;
        end
        S_INCC: begin
          rf_addr <= {rp, opnd[3:1], 1'b1};
          rf_wdata <= pair_next[7:0]; // RULE2 RULE4
          rf_we <= 1'b1;
          state <= S_WAIT;
        end
        S_WAIT: begin
          if (last) begin
            done <= 1'b1;
            state <= S_IDLE;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end
endmodule // ext_data_or_stack_ops

/* File: rtl/ext_ops_defs.vh */
`ifndef EXT_OPS_DEFS_VH
`define EXT_OPS_DEFS_VH
// ==========================================
// opcodes
`define OP_LDC_AUTOINC_ST   8'hd3
`define OP_LDX_LOAD         8'h82
`define OP_LDX_STORE        8'h92
`define OP_LDX_AI_LOAD      8'h83
`define OP_LDX_AI_STORE     8'h93
`define OP_NOP              8'hff
`define OP_OR_RR            8'h42
`define OP_POP_R            8'h50
`define OP_POP_IR           8'h51
`define OP_PUSH_R           8'h70
`define OP_PUSH_IR          8'h71
// ==========================================
// register file and operand fields
`define WREG_NIBBLE         4'he
`define SP_HIGH_ADDR        8'hfe
`define SP_LOW_ADDR         8'hff
`define SP_RESET            16'h0000
// ==========================================
// flag bit positions in the flag byte
`define FLAG_C              7
`define FLAG_Z              6
`define FLAG_S              5
`define FLAG_V              4
`define FLAG_D              3
`define FLAG_H              2
// ==========================================
// cycle counts
`define CYC_NOP             5'd6
`define CYC_LDX             5'd12
`define CYC_LDX_AI          5'd18
`define CYC_OR              5'd6
`define CYC_POP             5'd10
`define CYC_PUSH_INT        5'd10
`define CYC_PUSH_EXT        5'd12
`define CYC_ILLEGAL         5'd6
`endif

/* File: rtl/operand_resolve.v */
`timescale 1ns/10ps
`include "ext_ops_defs.vh"
// ==========================================
// maps an operand byte to a register-file address
module operand_resolve (
  input  wire [7:0] operand,
  input  wire [3:0] rp,
  output wire [7:0] address
);
  assign address = (operand[7:4] == `WREG_NIBBLE) ? {rp, operand[3:0]} : operand; // RULE8
endmodule // operand_resolve

/* File: rtl/cycle_timer.v */
`timescale 1ns/10ps
`include "ext_ops_defs.vh"
// ==========================================
// counts an instruction's cycles down to its final cycle
module cycle_timer #(
  parameter W = 5
) (
  input  wire         mclk,
  input  wire         srst,
  input  wire         load,
  input  wire [W-1:0] count,
  output wire         last
);
  reg [W-1:0] remain;
  always @(posedge mclk) begin
    if (srst)
      remain <= {W{1'b0}};
    else if (load)
      remain <= count - {{(W-1){1'b0}}, 1'b1};
    else if (remain != {W{1'b0}})
      remain <= remain - {{(W-1){1'b0}}, 1'b1};
  end
  assign last = (remain == {{(W-1){1'b0}}, 1'b1});
endmodule // cycle_timer

/* File: testbench/ext_ops_chk.sv */
`timescale 1ns/10ps
`include "ext_ops_defs.vh"
module ext_ops_chk (
  input wire        mclk,
  input wire        srst,
  input wire        start,
  input wire        busy,
  input wire [7:0]  opcode,
  input wire        ext_stack,
  input wire [7:0]  flags_in,
  input wire        done,
  input wire        rf_we,
  input wire [7:0]  rf_addr,
  input wire [7:0]  rf_wdata,
  input wire        flags_we,
  input wire [7:0]  flags_out,
  input wire        mem_we,
  input wire [15:0] stack_pointer_pair
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  wire take = start & ~busy;
  sequence s_wait5;
    !done [*5];
  endsequence
  sequence s_still5;
    (!rf_we && !mem_we && !flags_we) [*5];
  endsequence
  property p_or_time;
    take && opcode == `OP_OR_RR |=> s_wait5 ##1 done;
  endproperty
  a_or_time: assert property (p_or_time) else $error("or length wrong");
  property p_nop_quiet;
    take && opcode == `OP_NOP |=> s_still5 ##1 done;
  endproperty
  a_nop_quiet: assert property (p_nop_quiet) else $error("nop not idle");
  property p_load_external_autoinc_time;
    take && (opcode == `OP_LDX_AI_LOAD || opcode == `OP_LDX_AI_STORE) |-> ##18 done;
  endproperty
  a_load_external_autoinc_time: assert property (p_load_external_autoinc_time) else $error("block copy length wrong");
  property p_push_ext;
    take && opcode == `OP_PUSH_R && ext_stack |-> ##12 done;
  endproperty
  a_push_ext: assert property (p_push_ext) else $error("push length wrong");
  property p_push_ir;
    take && opcode == `OP_PUSH_IR |-> ##10 done;
  endproperty
  a_push_ir: assert property (p_push_ir) else $error("push ind length wrong");
  property p_pop_time;
    take && (opcode == `OP_POP_R || opcode == `OP_POP_IR) |-> ##10 done;
  endproperty
  a_pop_time: assert property (p_pop_time) else $error("pop length wrong");
  property p_or_flags;
    flags_we |-> !flags_out[`FLAG_V] && flags_out[`FLAG_Z] == (rf_wdata == 8'h00)
      && flags_out[`FLAG_S] == rf_wdata[7];
  endproperty
  a_or_flags: assert property (p_or_flags) else $error("result flags wrong");
  property p_flags_kept;
    flags_we |-> flags_out[`FLAG_C] == flags_in[`FLAG_C]
      && flags_out[`FLAG_D] == flags_in[`FLAG_D] && flags_out[`FLAG_H] == flags_in[`FLAG_H];
  endproperty
  a_flags_kept: assert property (p_flags_kept) else $error("kept flags changed");
  property p_sp_low;
    rf_we && rf_addr == `SP_LOW_ADDR |=> stack_pointer_pair[7:0] == $past(rf_wdata);
  endproperty
  a_sp_low: assert property (p_sp_low) else $error("stack low byte stale");
endmodule // ext_ops_chk
bind ext_data_or_stack_ops ext_ops_chk ext_ops_chk_i (.mclk, .srst, .start, .busy, .opcode,
  .ext_stack, .flags_in, .done, .rf_we, .rf_addr, .rf_wdata, .flags_we, .flags_out, .mem_we,
  .stack_pointer_pair);

/* File: testbench/mem_model.sv */
`timescale 1ns/10ps
module mem_model (
  input  logic        mclk,
  input  logic [15:0] mem_addr,
  input  logic        mem_rd,
  input  logic        mem_we,
  input  logic        mem_is_prog,
  input  logic [7:0]  mem_wdata,
  output logic [7:0]  mem_rdata
);
  // program space in the upper half, data space in the lower half
  logic [7:0]  m [0:131071];
  logic [7:0]  last = 8'h00;
  wire  [16:0] key = {mem_is_prog, mem_addr};
  // bus floats between strobes: toggling data exposes a late sample
  assign mem_rdata = mem_rd ? m[key] : ~last;
  always @(posedge mclk) begin
    last <= mem_rdata;
    if (mem_we) m[key] <= mem_wdata;
  end
endmodule // mem_model

/* File: testbench/tb.sv */
`timescale 1ns/10ps
`include "ext_ops_defs.vh"
module tb;
  logic        mclk = 1'b0;
  logic        srst = 1'b1;
  logic        start = 1'b0;
  logic        ext_stack = 1'b0;
  logic [3:0]  rp = 4'h1;
  logic [7:0]  opcode = 8'h00;
  logic [7:0]  operand = 8'h00;
  logic [7:0]  flags_in = 8'h00;
  logic [7:0]  rf [256];
  wire  [7:0]  rf_rdata, rf_addr, rf_wdata, flags_out, mem_rdata, mem_wdata;
  wire  [15:0] mem_addr, stack_pointer_pair;
  wire         busy, done, illegal, rf_we, flags_we, mem_rd, mem_we, mem_is_prog;
  integer      bad_count = 0;
  integer      tests_run = 0;
  always #2.5 mclk = ~mclk;
  assign rf_rdata = rf[rf_addr];
  always @(posedge mclk) if (rf_we) rf[rf_addr] <= rf_wdata;
  ext_data_or_stack_ops ext_data_or_stack_ops_i (.mclk, .srst, .start, .opcode, .operand, .rp,
    .ext_stack, .flags_in, .rf_rdata, .mem_rdata, .busy, .done, .illegal, .rf_addr, .rf_we,
    .rf_wdata, .flags_out, .flags_we, .mem_addr, .mem_rd, .mem_we, .mem_wdata, .mem_is_prog,
    .stack_pointer_pair);
  mem_model mem_model_i (.mclk, .mem_addr, .mem_rd, .mem_we, .mem_is_prog, .mem_wdata,
    .mem_rdata);
  // ==========
  // shared tasks
  task chk(input string what, input logic [15:0] seen, exp);
    tests_run = tests_run + 1;
    if (seen !== exp) begin
      bad_count = bad_count + 1;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one extra cycle after done so the last register write lands
  task run(input logic [7:0] op, opr, input logic [15:0] n);
    integer k;
    opcode = op;
    operand = opr;
    start = 1'b1;
    @(posedge mclk);
    #1 start = 1'b0;
    k = 1;
    while (done !== 1'b1 && k < 40) begin
      @(posedge mclk);
      #1 k = k + 1;
    end
    chk("cycles", k[15:0], n);
    @(posedge mclk);
    #1;
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // ==========
  // scenarios
  task t_or;
    rf[8'h11] = 8'h34;
    rf[8'h1e] = 8'h8d;
    flags_in = 8'h9c;
    run(`OP_OR_RR, 8'h1e, 6);
    chk("or dst", {8'h00, rf[8'h11]}, 16'h00bd);
    chk("or src", {8'h00, rf[8'h1e]}, 16'h008d);
    chk("or flags", {8'h00, flags_out}, 16'h00ac);
    flags_in = 8'h00;
    run(`OP_OR_RR, 8'h23, 6);
    chk("zero flags", {8'h00, flags_out}, 16'h0040);
    run(`OP_NOP, 8'h00, 6);
  endtask
  task t_lde;
    rf[8'h16] = 8'h40;
    rf[8'h17] = 8'ha2;
    mem_model_i.m[17'h040a2] = 8'h22;
    run(`OP_LDX_LOAD, 8'h26, 12);
    chk("lde load", {8'h00, rf[8'h12]}, 16'h0022);
    rf[8'h17] = 8'h4a;
    rf[8'h12] = 8'h5a;
    run(`OP_LDX_STORE, 8'h26, 12);
    chk("lde store", {8'h00, mem_model_i.m[17'h0404a]}, 16'h005a);
  endtask
  task t_load_external_autoinc;
    rf[8'h12] = 8'h22;
    rf[8'h23] = 8'hc3;
    mem_model_i.m[17'h0404a] = 8'hab;
    run(`OP_LDX_AI_LOAD, 8'h26, 18);
    chk("load_external_autoinc data", {8'h00, rf[8'h22]}, 16'h00ab);
    chk("load_external_autoinc pair", {rf[8'h16], rf[8'h17]}, 16'h404b);
    run(`OP_LDX_AI_STORE, 8'h26, 18);
    chk("load_external_autoinc store", {8'h00, mem_model_i.m[17'h0404b]}, 16'h00c3);
    chk("load_external_autoinc reg", {8'h00, rf[8'h12]}, 16'h0024);
    rf[8'h16] = 8'h30;
    rf[8'h17] = 8'hff;
    rf[8'h12] = 8'h20;
    rf[8'h20] = 8'h22;
    run(`OP_LDC_AUTOINC_ST, 8'h26, 12);
    chk("load_program_autoinc prog", {8'h00, mem_model_i.m[17'h130ff]}, 16'h0022);
    chk("load_program_autoinc pair", {rf[8'h16], rf[8'h17]}, 16'h3100);
    chk("load_program_autoinc reg", {8'h00, rf[8'h12]}, 16'h0021);
  endtask
  task t_stack;
    ext_stack = 1'b1;
    chk("sp reset", stack_pointer_pair, 16'h0000);
    rf[8'h34] = 8'h5c;
    run(`OP_PUSH_R, 8'h34, 12);
    chk("push data", {8'h00, mem_model_i.m[17'h0ffff]}, 16'h005c);
    rf[8'h16] = 8'h35;
    rf[8'h35] = 8'h77;
    run(`OP_PUSH_IR, 8'he6, 10);
    chk("push sp", stack_pointer_pair, 16'hfffe);
    run(`OP_POP_R, 8'h40, 10);
    chk("pop data", {8'h00, rf[8'h40]}, 16'h0077);
    chk("pop sp", stack_pointer_pair, 16'hffff);
    rf[8'h16] = 8'h41;
    run(`OP_POP_IR, 8'he6, 10);
    chk("pop ind", {8'h00, rf[8'h41]}, 16'h005c);
    chk("sp wrap", stack_pointer_pair, 16'h0000);
    ext_stack = 1'b0;
    run(8'h00, 8'h00, 6);
    chk("illegal", {15'h0000, illegal}, 16'h0001);
  endtask
  initial begin
    for (int i = 0; i < 256; i++) rf[i] = 8'h00;
    repeat (8) @(posedge mclk);
    #1 srst = 1'b0;
    t_or();
    t_lde();
    t_load_external_autoinc();
    t_stack();
    final_report();
  end
  initial begin
    #20000;
    bad_count = bad_count + 1;
    final_report();
  end
endmodule // tb
